/* File: hdl/osw_pkg.sv */
// Package for the oscillator stabilisation wait block: wait counts, select codes,
// encoding variants and the decode of the select field.
// Assumes one system clock; the oscillator runs slower and is seen as a tick.
package osw_pkg;

  // Width of the wait counter; must hold the longest count (131,072)
  localparam int OSW_CNT_W = 18;

  // Encoding variants of the select field
  localparam logic [1:0] OSW_VAR_A = 2'h0;
  localparam logic [1:0] OSW_VAR_B = 2'h1;
  localparam logic [1:0] OSW_VAR_WIDE = 2'h2;

  // Select code for a driven external clock
  localparam logic [3:0] OSW_SEL_EXT = 4'h5;

  // Wait counts in oscillator cycles
  localparam logic [OSW_CNT_W-1:0] OSW_N2 = 18'h00002;
  localparam logic [OSW_CNT_W-1:0] OSW_N4 = 18'h00004;
  localparam logic [OSW_CNT_W-1:0] OSW_N8 = 18'h00008;
  localparam logic [OSW_CNT_W-1:0] OSW_N16 = 18'h00010;
  localparam logic [OSW_CNT_W-1:0] OSW_N32 = 18'h00020;
  localparam logic [OSW_CNT_W-1:0] OSW_N128 = 18'h00080;
  localparam logic [OSW_CNT_W-1:0] OSW_N256 = 18'h00100;
  localparam logic [OSW_CNT_W-1:0] OSW_N512 = 18'h00200;
  localparam logic [OSW_CNT_W-1:0] OSW_N1K = 18'h00400;
  localparam logic [OSW_CNT_W-1:0] OSW_N2K = 18'h00800;
  localparam logic [OSW_CNT_W-1:0] OSW_N4K = 18'h01000;
  localparam logic [OSW_CNT_W-1:0] OSW_N8K = 18'h02000;
  localparam logic [OSW_CNT_W-1:0] OSW_N16K = 18'h04000;
  localparam logic [OSW_CNT_W-1:0] OSW_N32K = 18'h08000;
  localparam logic [OSW_CNT_W-1:0] OSW_N64K = 18'h10000;
  localparam logic [OSW_CNT_W-1:0] OSW_N128K = 18'h20000;

  // Reset values of the clock gate and oscillator enable outputs
  localparam logic OSW_GATE_RST = 1'b0;
  localparam logic OSW_OSC_EN_RST = 1'b0;

  // Controller states
  typedef enum logic [1:0] {
    OSW_HALTED,
    OSW_START,
    OSW_WAIT,
    OSW_RUN
  } osw_state_t;

  // Select code to wait count; the top bit only counts in the wide variant
  function automatic logic [OSW_CNT_W-1:0] osw_decode(input logic [1:0] variant,
                                                      input logic [3:0] sel);
    logic [OSW_CNT_W-1:0] n;
    n = OSW_N8K;
    if (variant == OSW_VAR_WIDE && sel[3]) begin
      case (sel[2:0])
        3'h0: n = OSW_N256;
        3'h1: n = OSW_N512;
        3'h2: n = OSW_N32K;
        3'h3: n = OSW_N64K;
        3'h4: n = OSW_N128K;
        3'h5: n = OSW_N4;
        3'h6: n = OSW_N32;
        default: n = OSW_N128;
      endcase
    end else begin
      case (sel[2:0])
        3'h0: n = OSW_N8K;
        3'h1: n = OSW_N16K;
        3'h2: n = (variant == OSW_VAR_A) ? OSW_N32K : OSW_N1K;
        3'h3: n = (variant == OSW_VAR_A) ? OSW_N64K : OSW_N2K;
        3'h4: n = (variant == OSW_VAR_A) ? OSW_N128K : OSW_N4K;
        3'h5: n = OSW_N2;
        3'h6: n = OSW_N8;
        default: n = OSW_N16;
      endcase
    end
    return n;
  endfunction

endpackage

/* File: hdl/osw_cnt_if.sv */
// Interface between the wait controller and its oscillator cycle counter.
// Assumes both ends share the system clock.
`timescale 1ns/100ps
`default_nettype none
interface osw_cnt_if;
  import osw_pkg::*;
  logic clear;
  logic tick;
  logic [OSW_CNT_W-1:0] target;
  logic term;
  logic [OSW_CNT_W-1:0] count;
  modport ctrl (output clear, output tick, output target, input term, input count);
  modport cnt (input clear, input tick, input target, output term, output count);
endinterface
`default_nettype wire

/* File: hdl/osw_wait_cnt.sv */
// Oscillator cycle counter for the stabilisation wait.
// Assumes tick is a one-cycle pulse per oscillator cycle, synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module osw_wait_cnt
  import osw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controller side
  osw_cnt_if.cnt cif
);

  logic [OSW_CNT_W-1:0] count_reg;
  logic [OSW_CNT_W-1:0] count_next;

  // Terminal count on the tick that completes the chosen number of cycles
  assign cif.term = cif.tick && (count_reg == cif.target - OSW_CNT_W'(1));
  assign cif.count = count_reg;

  // Clear wins over counting, so a halted oscillator leaves no partial count
  always_comb begin
    count_next = count_reg;
    if (cif.clear) begin
      count_next = '0;
    end else if (cif.tick) begin
      count_next = count_reg + OSW_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/osw_top.sv */
// Oscillator stabilisation wait: holds the system clock off the CPU and
// peripherals until the oscillator has run the selected number of cycles.
// Assumes osc_tick pulses once per oscillator cycle while the oscillator runs,
// and that select bits are stable before a wake request.
`timescale 1ns/100ps
`default_nettype none
module osw_top
  import osw_pkg::*;
#(
  parameter logic [1:0] VARIANT = OSW_VAR_A
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Mode control from the power manager
  input wire logic active_req,
  // Oscillator status
  input wire logic osc_started,
  input wire logic osc_tick,
  input wire logic ext_clk_used,
  // Select bits from the first and third system control registers
  input wire logic wait_sel_bit0,
  input wire logic wait_sel_bit1,
  input wire logic wait_sel_bit2,
  input wire logic wait_sel_bit3,
  // Clock gating and status
  output logic osc_enable,
  output logic sys_clk_gate,
  output logic wait_busy
);

  osw_state_t state_reg;
  osw_state_t state_next;
  logic gate_reg;
  logic gate_next;
  logic osc_en_reg;
  logic osc_en_next;
  logic busy_reg;
  logic busy_next;
  logic [OSW_CNT_W-1:0] target_reg;
  logic [OSW_CNT_W-1:0] target_next;
  logic [3:0] sel;

  osw_cnt_if cif ();

  osw_wait_cnt u_cnt (
    .clk (clk),
    .rst (rst),
    .cif (cif)
  );

  // Fourth bit is ignored outside the wide variant
  assign sel = {(VARIANT == OSW_VAR_WIDE) ? wait_sel_bit3 : 1'b0,
                wait_sel_bit2, wait_sel_bit1, wait_sel_bit0};

  // Counter runs only while waiting; any other state holds it cleared
  assign cif.clear = (state_reg != OSW_WAIT);
  assign cif.tick = osc_tick && (state_reg == OSW_WAIT);
  assign cif.target = target_reg;

  // Wake sequencer: halted, oscillation start, wait count, run.
  // ext_clk_used is not consulted: a non-external code with an external clock
  // simply runs the longer or shorter count, with no protection.
  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    gate_next = gate_reg;
    osc_en_next = osc_en_reg;
    busy_next = busy_reg;
    case (state_reg)
      OSW_HALTED: begin
        gate_next = 1'b0;
        busy_next = 1'b0;
        osc_en_next = 1'b0;
        if (active_req) begin
          osc_en_next = 1'b1;
          busy_next = 1'b1;
          target_next = osw_decode(VARIANT, sel);
          state_next = OSW_START;
        end
      end
      OSW_START: begin
        if (!active_req) begin
          state_next = OSW_HALTED;
          osc_en_next = 1'b0;
          busy_next = 1'b0;
        end else if (osc_started) begin
          state_next = OSW_WAIT;
        end
      end
      OSW_WAIT: begin
        if (!active_req) begin
          state_next = OSW_HALTED;
          osc_en_next = 1'b0;
          busy_next = 1'b0;
        end else if (cif.term) begin
          state_next = OSW_RUN;
          gate_next = 1'b1;
          busy_next = 1'b0;
        end
      end
      OSW_RUN: begin
        if (!active_req) begin
          state_next = OSW_HALTED;
          gate_next = 1'b0;
          osc_en_next = 1'b0;
        end
      end
      default: begin
        state_next = OSW_HALTED;
        gate_next = 1'b0;
        osc_en_next = 1'b0;
        busy_next = 1'b0;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= OSW_HALTED;
      target_reg <= OSW_N8K;
      gate_reg <= OSW_GATE_RST;
      osc_en_reg <= OSW_OSC_EN_RST;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      target_reg <= target_next;
      gate_reg <= gate_next;
      osc_en_reg <= osc_en_next;
      busy_reg <= busy_next;
    end
  end

  assign osc_enable = osc_en_reg;
  assign sys_clk_gate = gate_reg;
  assign wait_busy = busy_reg;

  // Gate never open unless the count has completed
  property p_gate_only_run;
    @(posedge clk) disable iff (rst)
    sys_clk_gate |-> (state_reg == OSW_RUN);
  endproperty
  a_gate_only_run: assert property (p_gate_only_run)
    else $error("clock gate open outside run state");

  // Gate opens exactly one cycle after terminal count
  property p_open_after_term;
    @(posedge clk) disable iff (rst)
    (state_reg == OSW_WAIT && cif.term && active_req) |=> sys_clk_gate;
  endproperty
  a_open_after_term: assert property (p_open_after_term)
    else $error("gate did not open after terminal count");

  // Gate rises only after a counting phase that ended in terminal count
  sequence s_counted;
    (state_reg == OSW_WAIT) && cif.term;
  endsequence
  property p_rise_needs_count;
    @(posedge clk) disable iff (rst)
    $rose(sys_clk_gate) |-> $past(state_reg == OSW_WAIT && cif.term);
  endproperty
  a_rise_needs_count: assert property (p_rise_needs_count)
    else $error("gate rose without a completed count");

  // Wake goes through oscillation start before counting
  sequence s_wake;
    (state_reg == OSW_HALTED) && active_req;
  endsequence
  property p_wake_start;
    @(posedge clk) disable iff (rst)
    s_wake |=> (state_reg == OSW_START) && osc_enable && !sys_clk_gate;
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("wake did not enter oscillation start");

  // Counter held at zero whenever the oscillator is halted
  property p_halt_clears;
    @(posedge clk) disable iff (rst)
    !osc_enable |=> (cif.count == '0);
  endproperty
  a_halt_clears: assert property (p_halt_clears)
    else $error("counter not cleared while halted");

  // External clock code waits two cycles in every variant
  property p_ext_code;
    @(posedge clk) disable iff (rst)
    (s_wake and (sel == OSW_SEL_EXT)) |=> (target_reg == OSW_N2);
  endproperty
  a_ext_code: assert property (p_ext_code)
    else $error("external clock code not two cycles");

  // Code 010 gives the variant's own count
  property p_code2;
    @(posedge clk) disable iff (rst)
    (s_wake and (sel == 4'h2))
      |=> (target_reg == ((VARIANT == OSW_VAR_A) ? OSW_N32K : OSW_N1K));
  endproperty
  a_code2: assert property (p_code2)
    else $error("code 010 count wrong for variant");

  // Wide variant with fourth bit set and low code 000 waits 256
  property p_wide;
    @(posedge clk) disable iff (rst)
    (s_wake and (sel == 4'h8)) |=> (target_reg == OSW_N256);
  endproperty
  a_wide: assert property (p_wide)
    else $error("fourth select bit not honoured");

  // An external clock does not change the count of an ordinary code
  property p_no_guard;
    @(posedge clk) disable iff (rst)
    (s_wake and ext_clk_used and (sel == 4'h0)) |=> (target_reg == OSW_N8K);
  endproperty
  a_no_guard: assert property (p_no_guard)
    else $error("external clock altered the count");

  // Two-cycle wait completes within two ticks of counting
  property p_two_ticks;
    @(posedge clk) disable iff (rst)
    (s_counted and (target_reg == OSW_N2)) |-> $past(cif.count) == 18'h00000
      || cif.count == 18'h00001;
  endproperty
  a_two_ticks: assert property (p_two_ticks)
    else $error("two-cycle wait ended on wrong count");

endmodule
`default_nettype wire

/* File: bench/osw_osc_model.sv */
// Oscillator model: start delay after enable, then one tick every DIV clocks.
// Assumes osc_enable comes from the block under test.
`timescale 1ns/100ps
`default_nettype none
module osw_osc_model #(
  parameter int START_CYC = 5,
  parameter int DIV = 1
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Oscillator control and status
  input wire logic osc_enable,
  output logic osc_started,
  output logic osc_tick
);
  int cnt;
  int ph;
  // A halted oscillator shows neither start nor ticks, so a restart begins from zero.
  // Ticks are steady from the first one, so every selected wait covers settling.
  always_ff @(posedge clk) begin
    if (rst || !osc_enable) begin
      cnt <= 0;
      ph <= 0;
      osc_started <= 1'b0;
      osc_tick <= 1'b0;
    end else if (!osc_started) begin
      cnt <= cnt + 1;
      osc_started <= (cnt == START_CYC - 1);
    end else begin
      ph <= (ph == DIV - 1) ? 0 : ph + 1;
      osc_tick <= (ph == DIV - 1);
    end
  end
endmodule
`default_nettype wire

/* File: bench/osw_top_tb.sv */
// Testbench: three select encodings side by side, each with its own oscillator.
// Assumes the oscillator model beside it; wait lengths are compared against code 101.
`timescale 1ns/100ps
`default_nettype none
module osw_top_tb;
  import osw_pkg::*;
  localparam logic [1:0] VARS [3] = '{OSW_VAR_A, OSW_VAR_B, OSW_VAR_WIDE};
  localparam int DIVS [3] = '{1, 2, 1};
  logic clk;
  logic rst;
  logic active_req;
  logic ext_clk_used;
  logic [3:0] sel;
  logic [2:0] oen, gate, busy, started, tick;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int base [3];
  logic [3:0] codes [12] = '{4'h6, 4'h7, 4'hd, 4'he, 4'hf, 4'h8, 4'h9, 4'ha, 4'h2, 4'h3, 4'h4,
                             4'h0};

  // One block per encoding; the slower oscillator proves the count is in ticks
  for (genvar i = 0; i < 3; i++) begin : g
    osw_top #(.VARIANT(VARS[i])) dut (
      .clk(clk), .rst(rst), .active_req(active_req), .osc_started(started[i]),
      .osc_tick(tick[i]), .ext_clk_used(ext_clk_used), .wait_sel_bit0(sel[0]),
      .wait_sel_bit1(sel[1]), .wait_sel_bit2(sel[2]), .wait_sel_bit3(sel[3]),
      .osc_enable(oen[i]), .sys_clk_gate(gate[i]), .wait_busy(busy[i]));
    osw_osc_model #(.START_CYC(3 + 2 * i), .DIV(DIVS[i])) osc (
      .clk(clk), .rst(rst), .osc_enable(oen[i]), .osc_started(started[i]),
      .osc_tick(tick[i]));
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short; the planned run needs about 67k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      stop_test();
    end
  end

  // Expected wait count for an encoding and a select value
  function automatic int exp_n(int v, logic [3:0] s);
    int ta [8] = '{8192, 16384, 32768, 65536, 131072, 2, 8, 16};
    int tb [8] = '{8192, 16384, 1024, 2048, 4096, 2, 8, 16};
    int tw [8] = '{256, 512, 32768, 65536, 131072, 4, 32, 128};
    if (v == 0) return ta[s[2:0]];
    if (v == 2 && s[3]) return tw[s[2:0]];
    return tb[s[2:0]];
  endfunction

  task automatic stop_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_bit(logic got, logic exp, string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic chk_num(int got, int exp, string what);
    samples_checked++;
    if (got != exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask

  // Wake, note the cycle each gate opens, then return to halt
  task automatic wake(logic [3:0] s, output int lat [3]);
    int lim;
    int n;
    lim = 64;
    for (int i = 0; i < 3; i++) begin
      lat[i] = -1;
      n = exp_n(i, s) * DIVS[i];
      if (n <= 17000 && n + 64 > lim) lim = n + 64;
    end
    sel = s;
    ext_clk_used = (s[2:0] == 3'h5);
    active_req = 1'b1;
    for (int c = 1; c <= lim; c++) begin
      @(posedge clk);
      #1;
      // A late select change must not alter the running wait
      if (c == 4) sel = ~s;
      for (int i = 0; i < 3; i++) begin
        if (c == 1) chk_bit(busy[i] & oen[i], 1'b1, "wake not seen");
        if (lat[i] < 0 && gate[i] === 1'b1) begin
          lat[i] = c;
          chk_bit(busy[i], 1'b0, "busy after gate");
        end
      end
    end
    active_req = 1'b0;
    @(posedge clk);
    #1;
    for (int i = 0; i < 3; i++) chk_bit(gate[i], 1'b0, "gate after halt");
    @(posedge clk);
    #1;
    chk_bit(|oen, 1'b0, "oscillator still on");
  endtask

  // Wait length relative to code 101; long counts must keep the gate shut
  task automatic run_code(logic [3:0] s);
    int lat [3];
    wake(s, lat);
    for (int i = 0; i < 3; i++) begin
      if (exp_n(i, s) * DIVS[i] <= 17000)
        chk_num(lat[i] - base[i], (exp_n(i, s) - 2) * DIVS[i], "wait length");
      else
        chk_num(lat[i], -1, "early release");
    end
  endtask

  // Abort in mid-wait, then a full wait must start from a cleared counter.
  // The wake runs an ordinary code with an external clock: the block does not
  // guard this, so the long count must simply run on unchanged.
  task automatic abort_case();
    sel = 4'h0;
    ext_clk_used = 1'b1;
    active_req = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    chk_bit(&busy & ~|gate, 1'b1, "external clock cut the wait");
    active_req = 1'b0;
    @(posedge clk);
    #1;
    chk_bit(|{oen, gate, busy}, 1'b0, "abort");
    @(posedge clk);
    #1;
    run_code(4'h7);
  endtask

  initial begin
    rst = 1'b1;
    active_req = 1'b0;
    ext_clk_used = 1'b0;
    sel = 4'h0;
    repeat (2) @(posedge clk);
    #1;
    // Reset is only let go with every oscillator halted, so no wait is cut short
    rst = 1'b0;
    chk_bit(|{oen, gate, busy}, 1'b0, "reset state");
    wake(4'h5, base);
    chk_num(base[2] - base[0], 4, "start time");
    abort_case();
    foreach (codes[k]) run_code(codes[k]);
    stop_test();
  end
endmodule
`default_nettype wire
